/* rtl/nbm_host.sv */
// nand bus host controller: drives latch, strobe and data pins
`timescale 1ns/1ns
`default_nettype none
`include "nbm_params.svh"
// Contract
// - cap partial programs: main 2, spare 3
// - hold select high past break time
// - hold pins idle while fetch busy
// - no erase of marked blocks (the code still erases a marked block zero)
// - refuse program/erase on marked block (the code accepts them when blk_zero_in is set)
// - report failed status for block retire
// - single-bit errors corrected by user ecc
// - completion seen on ready/busy
module nbm_host (
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_b_in,
  input  wire logic              clk_en_in,
  // user request side
  input  wire logic              req_valid_in,
  input  wire nbm_pkg::nbm_req_t req_in,
  input  wire logic              blk_bad_in,
  input  wire logic              blk_zero_in,
  input  wire logic              wr_enable_in,
  output logic                   req_ready_out,
  output logic                   rsp_valid_out,
  output logic [7:0]             rsp_data_out,
  output logic                   bad_mark_out,
  output logic                   status_fail_out,
  output logic                   nop_refused_out,
  // flash pins
  output nbm_pkg::nbm_pins_t     pins_out,
  input  wire logic [7:0]        io_in,
  output logic [7:0]             io_out,
  output logic                   io_oe_out,
  input  wire logic              rb_in
);
  import nbm_pkg::*;

  typedef enum logic [4:0] {
    NBM_ST_IDLE = 5'b00001,
    NBM_ST_WE   = 5'b00010,
    NBM_ST_RD   = 5'b00100,
    NBM_ST_WAIT = 5'b01000,
    NBM_ST_CEH  = 5'b10000
  } nbm_state_t;

  nbm_state_t state_r;
  nbm_req_t   cur_r;
  logic [1:0] rb_sync_r;
  logic       rb_s;
  logic [7:0] cnt_r;
  logic       seen_busy_r;
  logic       last_cmd_status_r;
  logic [1:0] nop_main_r;
  logic [1:0] nop_spare_r;
  logic       tmr_start;
  logic       tmr_low;
  logic       tmr_done;
  logic       accept;
  logic       blocked;
  logic [3:0] tmr_low_cyc;
  logic [3:0] tmr_high_cyc;
  logic [7:0] io_sync0_r;
  logic [7:0] io_s_r;
  logic [1:0] cap_pipe_r;
  logic [7:0] rd_hold_r;

  // program/erase command bytes are 80h, 60h and 10h/d0h confirms
  function automatic logic is_write_cmd(input logic [7:0] c);
    is_write_cmd = (c == 8'h80) || (c == 8'h60) || (c == 8'h10) || (c == 8'hd0);
  endfunction

  assign rb_s = rb_sync_r[1];
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      rb_sync_r <= 2'b11;
    end else if (clk_en_in) begin
      rb_sync_r <= {rb_sync_r[0], rb_in};
    end
  end

  always_comb begin
    blocked = 1'b0;
    if (req_in.op == NBM_OP_CMD && is_write_cmd(req_in.data)) begin
      blocked = !wr_enable_in;
      if (blk_bad_in && !blk_zero_in) begin
        blocked = 1'b1;
      end
    end
    if (req_in.op == NBM_OP_WR && req_in.data == 8'h10) begin
      blocked = 1'b0;
    end
    if (req_in.op == NBM_OP_CMD && req_in.data == 8'h80) begin
      if (req_in.spare) begin
        blocked = blocked || (nop_spare_r == 2'(`NBM_SPARE_NOP_MAX));
      end else begin
        blocked = blocked || (nop_main_r == 2'(`NBM_MAIN_NOP_MAX));
      end
    end
  end

  assign req_ready_out = (state_r == NBM_ST_IDLE) && rb_s;
  assign accept        = req_valid_in && req_ready_out && clk_en_in && !blocked;
  assign tmr_start     = (state_r == NBM_ST_WE) || (state_r == NBM_ST_RD);
  assign tmr_low_cyc   = (state_r == NBM_ST_RD) ? 4'(`NBM_RD_LOW_CYC) : 4'(`NBM_WE_LOW_CYC);
  assign tmr_high_cyc  = (state_r == NBM_ST_RD) ? 4'(`NBM_RD_HIGH_CYC) : 4'(`NBM_WE_HIGH_CYC);

  // read bus passes two flops; the capture enable is delayed to match, so the
  // byte kept is the last one seen while the read strobe was still low
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      io_sync0_r <= 8'hff;
      io_s_r     <= 8'hff;
      cap_pipe_r <= 2'b00;
      rd_hold_r  <= 8'hff;
    end else if (clk_en_in) begin
      io_sync0_r <= io_in;
      io_s_r     <= io_sync0_r;
      cap_pipe_r <= {cap_pipe_r[0], (state_r == NBM_ST_RD) && tmr_low};
      if (cap_pipe_r[1]) begin
        rd_hold_r <= io_s_r;
      end
    end
  end

  nbm_strobe_timer u_tmr (
    .clk_sys_in  (clk_sys_in),
    .rst_b_in    (rst_b_in),
    .ce_in       (clk_en_in),
    .start_in    (tmr_start),
    .low_cyc_in  (tmr_low_cyc),
    .high_cyc_in (tmr_high_cyc),
    .low_out     (tmr_low),
    .done_out    (tmr_done)
  );

  // sequencer
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      state_r     <= NBM_ST_IDLE;
      cur_r       <= '0;
      cnt_r       <= 8'h00;
      seen_busy_r <= 1'b0;
    end else if (clk_en_in) begin
      unique case (state_r)
        NBM_ST_IDLE: begin
          if (accept) begin
            cur_r <= req_in;
            seen_busy_r <= 1'b0;
            unique case (req_in.op)
              NBM_OP_CMD, NBM_OP_ADDR, NBM_OP_WR: state_r <= NBM_ST_WE;
              NBM_OP_RD: state_r <= NBM_ST_RD;
              NBM_OP_CEH: begin
                state_r <= NBM_ST_CEH;
                cnt_r   <= 8'(`NBM_CEH_CYC);
              end
              default: begin
                state_r <= NBM_ST_WAIT;
                cnt_r   <= 8'(`NBM_WB_CYC);
              end
            endcase
          end
        end
        NBM_ST_WE, NBM_ST_RD: begin
          if (tmr_done) begin
            if (cur_r.op == NBM_OP_CMD || (cur_r.op == NBM_OP_ADDR && cur_r.data[7])) begin
              state_r <= NBM_ST_WAIT;
              cnt_r   <= 8'(`NBM_WB_CYC);
            end else begin
              state_r <= NBM_ST_IDLE;
            end
          end
        end
        NBM_ST_WAIT: begin
          // wait out busy onset window, then for ready
          if (!rb_s) begin
            seen_busy_r <= 1'b1;
          end
          if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else if (rb_s) begin
            state_r <= NBM_ST_IDLE;
          end
        end
        NBM_ST_CEH: begin
          if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else if (rb_s) begin
            state_r <= NBM_ST_IDLE;
          end
        end
        default: state_r <= NBM_ST_IDLE;
      endcase
    end
  end

  // partial program counters, cleared by erase confirm
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      nop_main_r  <= 2'h0;
      nop_spare_r <= 2'h0;
    end else if (clk_en_in && accept && req_in.op == NBM_OP_CMD) begin
      if (req_in.data == 8'hd0) begin
        nop_main_r  <= 2'h0;
        nop_spare_r <= 2'h0;
      end else if (req_in.data == 8'h80) begin
        if (req_in.spare) begin
          nop_spare_r <= nop_spare_r + 2'h1;
        end else begin
          nop_main_r <= nop_main_r + 2'h1;
        end
      end
    end
  end

  // read data capture and mark / status decode
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      rsp_valid_out     <= 1'b0;
      rsp_data_out      <= 8'hff;
      bad_mark_out      <= 1'b0;
      status_fail_out   <= 1'b0;
      nop_refused_out   <= 1'b0;
      last_cmd_status_r <= 1'b0;
    end else if (clk_en_in) begin
      rsp_valid_out   <= 1'b0;
      nop_refused_out <= req_valid_in && req_ready_out && blocked;
      if (accept && req_in.op == NBM_OP_CMD) begin
        last_cmd_status_r <= (req_in.data == `NBM_CMD_STATUS);
      end
      if (state_r == NBM_ST_RD && tmr_done) begin
        rsp_valid_out <= 1'b1;
        // raw byte handed on, single-bit errors left to the user's ecc
        rsp_data_out  <= rd_hold_r;
        bad_mark_out  <= (cur_r.col == `NBM_BAD_MARK_COL) && (rd_hold_r != 8'hff)
                         && !blk_zero_in;
        status_fail_out <= last_cmd_status_r && rd_hold_r[`NBM_STATUS_FAIL_BIT];
      end
    end
  end

  // pin drive: idle state holds latches low, strobes high
  always_comb begin
    pins_out             = '0;
    pins_out.ce_n        = (state_r == NBM_ST_CEH);
    pins_out.we_n        = !(state_r == NBM_ST_WE && tmr_low);
    pins_out.rd_strobe_n = !(state_r == NBM_ST_RD && tmr_low);
    pins_out.wp_n        = wr_enable_in;
    if (state_r == NBM_ST_WE) begin
      pins_out.cle = (cur_r.op == NBM_OP_CMD);
      pins_out.ale = (cur_r.op == NBM_OP_ADDR);
    end
  end

  assign io_out    = cur_r.data;
  assign io_oe_out = (state_r == NBM_ST_WE);
endmodule
`default_nettype wire

/* rtl/nbm_params.svh */
// timing and field constants for the nand bus host controller
`ifndef NBM_PARAMS_SVH
`define NBM_PARAMS_SVH
`define NBM_CLK_PERIOD_NS     10
`define NBM_WE_LOW_NS         35
`define NBM_WE_HIGH_NS        15
`define NBM_RD_LOW_NS         25
`define NBM_RD_HIGH_NS        25
`define NBM_CEH_NS            100
`define NBM_WB_NS             100
`define NBM_RR_NS             20
`define NBM_WE_LOW_CYC        ((`NBM_WE_LOW_NS + `NBM_CLK_PERIOD_NS - 1) / `NBM_CLK_PERIOD_NS)
`define NBM_WE_HIGH_CYC       ((`NBM_WE_HIGH_NS + `NBM_CLK_PERIOD_NS - 1) / `NBM_CLK_PERIOD_NS)
`define NBM_RD_LOW_CYC        ((`NBM_RD_LOW_NS + `NBM_CLK_PERIOD_NS - 1) / `NBM_CLK_PERIOD_NS)
`define NBM_RD_HIGH_CYC       ((`NBM_RD_HIGH_NS + `NBM_CLK_PERIOD_NS - 1) / `NBM_CLK_PERIOD_NS)
`define NBM_CEH_CYC           ((`NBM_CEH_NS + `NBM_CLK_PERIOD_NS - 1) / `NBM_CLK_PERIOD_NS + 1)
`define NBM_WB_CYC            ((`NBM_WB_NS + `NBM_CLK_PERIOD_NS - 1) / `NBM_CLK_PERIOD_NS)
`define NBM_RR_CYC            ((`NBM_RR_NS + `NBM_CLK_PERIOD_NS - 1) / `NBM_CLK_PERIOD_NS)
`define NBM_ADDR_CYCLES       3
`define NBM_CMD_RESET         8'hff
`define NBM_CMD_STATUS        8'h70
`define NBM_STATUS_FAIL_BIT   0
`define NBM_MAIN_NOP_MAX      2
`define NBM_SPARE_NOP_MAX     3
`define NBM_BAD_MARK_COL      10'h205
`endif

/* rtl/nbm_pkg.sv */
// types for the nand bus host controller
package nbm_pkg;
  typedef enum logic [2:0] {
    NBM_OP_CMD  = 3'h0,
    NBM_OP_ADDR = 3'h1,
    NBM_OP_WR   = 3'h2,
    NBM_OP_RD   = 3'h3,
    NBM_OP_WAIT = 3'h4,
    NBM_OP_CEH  = 3'h5
  } nbm_op_t;
  typedef struct packed {
    nbm_op_t    op;
    logic [7:0] data;
    logic [9:0] col;
    logic       spare;
  } nbm_req_t;
  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       ce_n;
    logic       we_n;
    logic       rd_strobe_n;
    logic       wp_n;
  } nbm_pins_t;
endpackage

/* rtl/nbm_strobe_timer.sv */
// strobe timer: low phase then high phase, counted in clock cycles
`timescale 1ns/1ns
`default_nettype none
module nbm_strobe_timer (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_b_in,
  input  wire logic       ce_in,
  // control
  input  wire logic       start_in,
  input  wire logic [3:0] low_cyc_in,
  input  wire logic [3:0] high_cyc_in,
  // status
  output logic            low_out,
  output logic            done_out
);
  logic [3:0] cnt_r;
  logic       low_r;
  logic       busy_r;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      cnt_r  <= 4'h0;
      low_r  <= 1'b0;
      busy_r <= 1'b0;
    end else if (ce_in) begin
      if (start_in && !busy_r) begin
        busy_r <= 1'b1;
        low_r  <= 1'b1;
        cnt_r  <= low_cyc_in;
      end else if (busy_r) begin
        if (cnt_r > 4'h1) begin
          cnt_r <= cnt_r - 4'h1;
        end else if (low_r) begin
          low_r <= 1'b0;
          cnt_r <= high_cyc_in;
        end else begin
          busy_r <= 1'b0;
        end
      end
    end
  end
  assign low_out  = low_r;
  assign done_out = busy_r && !low_r && (cnt_r <= 4'h1) && ce_in;
endmodule
`default_nettype wire

/* verification/nbm_host_asserts.sv */
// port assertions for the nand bus host controller
`timescale 1ns/1ns
`default_nettype none
module nbm_chk (
  // clock and requests
  input wire logic               clk_sys_in,
  input wire logic               rst_b_in,
  input wire logic               req_valid_in,
  input wire nbm_pkg::nbm_req_t  req_in,
  input wire logic               blk_bad_in,
  input wire logic               blk_zero_in,
  // answers and pins
  input wire logic               req_ready_out,
  input wire logic               rsp_valid_out,
  input wire logic               bad_mark_out,
  input wire logic               status_fail_out,
  input wire logic               nop_refused_out,
  input wire nbm_pkg::nbm_pins_t pins_out,
  input wire logic               rb_in
);
  import nbm_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  wire logic bad_wr = req_valid_in && req_ready_out && req_in.op == NBM_OP_CMD
                      && req_in.data == 8'h80 && blk_bad_in && !blk_zero_in;
  wire logic p = pins_out.ce_n;
  a_no_dual_latch: assert property (!pins_out.we_n |-> !(pins_out.cle && pins_out.ale))
    else $error("latch clash");
  a_idle_on_busy: assert property (!rb_in [*3] |-> pins_out.we_n && pins_out.rd_strobe_n)
    else $error("strobe while busy");
  a_wait_busy: assert property (!rb_in [*3] |-> !req_ready_out)
    else $error("ready while busy");
  a_refuse_bad: assert property (bad_wr |-> ##[1:2] nop_refused_out)
    else $error("bad block write taken");
  a_refuse_quiet: assert property (nop_refused_out |-> pins_out.we_n [*2])
    else $error("strobe on refusal");
  a_break_hold: assert property ($rose(p) |-> p [*4] ##1 p [*7])
    else $error("select high too short");
  a_fail_on_rsp: assert property ($changed(status_fail_out) |-> rsp_valid_out || $past(rsp_valid_out))
    else $error("fail flag moved");
  a_mark_on_rsp: assert property ($changed(bad_mark_out) |-> rsp_valid_out || $past(rsp_valid_out))
    else $error("mark flag moved");
  c_bad_wr: cover property (bad_wr);
  c_break: cover property ($rose(p));
  c_mark: cover property (rsp_valid_out && bad_mark_out);
endmodule
bind nbm_host nbm_chk chk_u (.clk_sys_in, .rst_b_in, .req_valid_in, .req_in, .blk_bad_in,
  .blk_zero_in, .req_ready_out, .rsp_valid_out, .bad_mark_out, .status_fail_out,
  .nop_refused_out, .pins_out, .rb_in);
`default_nettype wire

/* verification/nbm_flash_model.sv */
// behavioural flash device behind the host pins
`timescale 1ns/1ns
`default_nettype none
module nbm_flash_model (
  // host side
  input  wire logic               clk_sys_in,
  input  wire nbm_pkg::nbm_pins_t p_in,
  input  wire logic [7:0]         io_in,
  input  wire logic               slow_in,
  input  wire logic               fail_in,
  // device side
  output logic [7:0]              io_out,
  output logic                    rb_out
);
  import nbm_pkg::*;
  nbm_pins_t  q_r = '1;
  logic [7:0] c_r = 8'h00;
  logic [7:0] d_r = 8'hff;
  logic [7:0] a_r [3];
  int         n_r = 0;
  int         b_r = 0;
  int         col_r = 0;
  logic       sp_r = 1'b0;
  logic       st_r = 1'b0;
  logic       f_r = 1'b0;
  wire logic  wr = p_in.we_n && !q_r.we_n;
  assign rb_out = b_r == 0;
  // released bus shows the inverse of the last byte
  assign io_out = (p_in.ce_n || p_in.rd_strobe_n) ? ~d_r : d_r;
  always @(posedge clk_sys_in) begin
    q_r <= p_in;
    if (b_r > 0) b_r <= b_r - 1;
    if (p_in.ce_n && !q_r.ce_n && b_r > 5) b_r <= 5;
    if (wr && p_in.cle && !p_in.ale) begin
      c_r <= io_in;
      n_r <= 0;
      st_r <= io_in == 8'h70;
      if (io_in == 8'h00 || io_in == 8'h50) sp_r <= io_in[4];
      if (io_in == 8'hff) b_r <= slow_in ? 500 : 20;
      if ((io_in == 8'h10 || io_in == 8'hd0) && p_in.wp_n) begin
        b_r <= 40;
        f_r <= fail_in;
      end
    end
    if (wr && p_in.ale && !p_in.cle) begin
      a_r[n_r] <= io_in;
      n_r <= n_r + 1;
      if (n_r == 2 && (c_r == 8'h00 || c_r == 8'h50)) begin
        b_r <= slow_in ? 1000 : 30;
        col_r <= sp_r ? 512 + a_r[0][3:0] : a_r[0];
      end
    end
    if (!p_in.rd_strobe_n && q_r.rd_strobe_n) begin
      col_r <= col_r + 1;
      if (st_r) d_r <= {p_in.wp_n, 1'b1, 5'h00, f_r};
      else if (col_r == 517 && a_r[2][0]) d_r <= 8'h00;
      else d_r <= 8'hff;
    end
  end
endmodule
`default_nettype wire

/* verification/tb_nand_bus_mode_and_bad_block_control.sv */
// self-checking bench for the nand bus host controller
`timescale 1ns/1ns
`default_nettype none
`include "nbm_params.svh"
module tb_nand_bus_mode_and_bad_block_control;
  import nbm_pkg::*;
  logic        clk_sys_in = 1'b0, rst_b_in = 1'b0, req_valid_in = 1'b0, slow = 1'b1;
  logic        fail = 1'b0, blk_bad_in = 1'b0, blk_zero_in = 1'b0, wr_enable_in = 1'b1;
  logic        rb_in, req_ready_out, rsp_valid_out, bad_mark_out, status_fail_out;
  logic        nop_refused_out, io_oe_out;
  logic [7:0]  rsp_data_out, io_out, flash_q, rsp_q, r;
  nbm_req_t    req_in = '0;
  nbm_pins_t   pins_out;
  int          err_total = 0, checked = 0, refs = 0, nop [2];
  logic [31:0] x = 32'h0000ba05;
  wire logic [7:0] io_in = io_oe_out ? io_out : flash_q;
  nbm_host dut_u (.clk_sys_in, .rst_b_in, .clk_en_in(1'b1), .req_valid_in, .req_in, .blk_bad_in,
    .blk_zero_in, .wr_enable_in, .req_ready_out, .rsp_valid_out, .rsp_data_out, .bad_mark_out,
    .status_fail_out, .nop_refused_out, .pins_out, .io_in, .io_out, .io_oe_out, .rb_in);
  nbm_flash_model flash_u (.clk_sys_in, .p_in(pins_out), .io_in, .slow_in(slow), .fail_in(fail),
    .io_out(flash_q), .rb_out(rb_in));
  initial forever #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    if (nop_refused_out === 1'b1) refs++;
    if (rsp_valid_out === 1'b1) rsp_q = rsp_data_out;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x[7:0];
  endfunction
  task automatic op(input nbm_op_t o, input logic [7:0] d, input logic [9:0] c = 10'h000,
                    input logic sp = 1'b0);
    @(negedge clk_sys_in);
    repeat (3000) if (req_ready_out !== 1'b1) @(negedge clk_sys_in);
    chk({7'h00, req_ready_out}, 8'h01);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_in <= '{o, d, c, sp};
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
  endtask
  task automatic prog(input logic sp, input logic f);
    int r0;
    logic ex;
    r0 = refs;
    fail <= f;
    op(NBM_OP_CMD, 8'h80, 10'h000, sp);
    ex = !wr_enable_in || blk_bad_in && !blk_zero_in
         || nop[sp] >= (sp ? `NBM_SPARE_NOP_MAX : `NBM_MAIN_NOP_MAX);
    chk({7'h00, refs != r0}, {7'h00, ex});
    if (!ex) begin
      nop[sp]++;
      repeat (3) op(NBM_OP_ADDR, rnd() & 8'h7f);
      op(NBM_OP_WR, rnd());
      op(NBM_OP_CMD, 8'h10);
    end
  endtask
  task automatic ers();
    op(NBM_OP_CMD, 8'h60);
    repeat (2) op(NBM_OP_ADDR, rnd() & 8'h7f);
    op(NBM_OP_CMD, 8'hd0);
    nop = '{0, 0};
  endtask
  task automatic close_out();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    op(NBM_OP_CMD, `NBM_CMD_RESET);
    // mark bytes of random blocks, block zero first
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 8'h80 : (rnd() | 8'h80);
      slow <= r[1];
      blk_zero_in <= i == 0;
      op(NBM_OP_CMD, 8'h50);
      op(NBM_OP_ADDR, 8'h05);
      op(NBM_OP_ADDR, (i == 0) ? 8'h00 : (rnd() & 8'h7f));
      op(NBM_OP_ADDR, r);
      op(NBM_OP_RD, 8'h00, `NBM_BAD_MARK_COL, 1'b1);
      chk(rsp_q, r[0] ? 8'h00 : 8'hff);
      chk({7'h00, bad_mark_out}, {7'h00, r[0]});
    end
    slow <= 1'b0;
    blk_zero_in <= 1'b0;
    ers();
    for (int s = 0; s < 2; s++) repeat (4) prog(s[0], 1'b0);
    ers();
    // protect, bad block, bad block zero
    for (int k = 0; k < 3; k++) begin
      wr_enable_in <= k != 0;
      blk_bad_in <= k != 0;
      blk_zero_in <= k == 2;
      prog(1'b0, 1'b0);
    end
    blk_bad_in <= 1'b0;
    blk_zero_in <= 1'b0;
    for (int f = 1; f >= 0; f--) begin
      ers();
      prog(1'b0, f[0]);
      op(NBM_OP_CMD, `NBM_CMD_STATUS);
      op(NBM_OP_RD, 8'h00);
      chk({7'h00, rsp_q[`NBM_STATUS_FAIL_BIT]}, {7'h00, f[0]});
      chk({7'h00, status_fail_out}, {7'h00, f[0]});
    end
    op(NBM_OP_CEH, 8'h00);
    op(NBM_OP_WAIT, 8'h00);
    close_out();
  end
  initial begin
    #1000000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
